// *** include/uart_ctl_params.svh ***
// constants for the serial channel control block: offsets, field positions, resets, timing
// assumes a host bus with 3-bit address, chip select, read and write strobes on the device clock
// Functional notes
// [RL1] receive-ready interrupt follows held character when enabled
// [RL2] transmit-empty interrupt follows holding-empty flag when enabled
// [RL3] mask bits 2,3 gate line/modem; 4..7 zero
// [RL4] identification read clears only top pending source; code clears only a reported line or transmit source, never receive or modem
// [RL5] codes: line 0110, rx 0100, tx 0010, modem 0000
// [RL6] bit0 low while pending, resets high, upper zero
// [RL7] format bits 1..0 pick 5 to 8 bits
// [RL8] stop bits: one, one-and-half, or two
// [RL9] format bit 3 enables parity send and check
// [RL10] bit 4 clear odd, set even parity
// [RL11] forced parity: 1 if bit4 clear, else 0
// [RL12] break bit holds serial output low
// [RL13] format bit 7 exposes divisor latch, resets zero
// [RL14] modem bits 0,1 drive inverted ready outputs
// [RL15] bit 3 enables interrupt pin; loop carrier
// [RL16] modem bit 2 supplies ring in loop-back
// [RL17] modem bit 4 loop-back; bits 5..7 zero
// [RL18] status bit 0 set while character held
// [RL19] overrun sets bit1, held character kept intact
// [RL20] bit 2 parity error, bit 3 framing error
// [RL21] bit 4 on whole frame of low input
// [RL22] bit5 holding empty, bit6 both empty, bit7 zero
// [RL23] loop-back maps modem controls onto modem inputs
// [RL24] interrupt asserts while any enabled source pends
// [RL25] host writes when empty, reads when ready
`ifndef UART_CTL_PARAMS_SVH
`define UART_CTL_PARAMS_SVH
`define ADDR_DATA        3'h0
`define ADDR_MASK        3'h1
`define ADDR_IDENT       3'h2
`define ADDR_FORMAT      3'h3
`define ADDR_MODEM_CTL   3'h4
`define ADDR_LINE_FLAGS  3'h5
`define ADDR_MODEM_IN    3'h6
`define ADDR_SCRATCH     3'h7
`define RST_MASK         8'h00
`define RST_FORMAT       8'h00
`define RST_MODEM_CTL    8'h00
`define RST_DIVISOR      16'h0001
`define IDENT_NONE       4'h1
`define IDENT_LINE       4'h6
`define IDENT_RX         4'h4
`define IDENT_TX         4'h2
`define IDENT_MODEM      4'h0
`define FMT_DLAB         7
`define FMT_BREAK        6
`define FMT_FORCE        5
`define FMT_EVEN         4
`define FMT_PAR_EN       3
`define FMT_STOP         2
`define MCTL_LOOP        4
`define MCTL_OUT2        3
`define MCTL_RING        2
`define MCTL_RTS         1
`define MCTL_DTR         0
`define OVERSAMPLE       16
`define START_MID        4'h7
`endif

// *** include/uart_ctl_pkg.sv ***
// types shared by the serial channel control block
// holds no constants; those live in the params header
`default_nettype none
package uart_ctl_pkg;
  typedef struct packed {
    logic       brk;
    logic       frame_err;
    logic       par_err;
    logic [7:0] data;
  } rx_word_t;
  typedef struct packed {
    logic cts;
    logic dsr;
    logic ring;
    logic carrier;
  } modem_in_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
endpackage : uart_ctl_pkg
`default_nettype wire

// *** hdl/uart_fifo.sv ***
// small synchronous fifo, valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module uart_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  // full and empty straight from the count so they never lie
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : uart_fifo
`default_nettype wire

// *** hdl/uart_ctl.sv ***
// one asynchronous serial channel: registers, interrupt priority, line format, transmit, receive
// assumes host strobes synchronous to clock; serial and modem pins are asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "uart_ctl_params.svh"
module uart_ctl (
  input  wire logic       clock,
  input  wire logic       srst,
  input  wire logic       cs,
  input  wire logic [2:0] addr,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] rdata,
  input  wire logic       rx_pin,
  output var  logic       tx_pin,
  input  wire logic       cts_n,
  input  wire logic       dsr_n,
  input  wire logic       ring_indicate_n,
  input  wire logic       carrier_detect_n,
  output var  logic       dtr_n,
  output var  logic       rts_n,
  output var  logic       irq,
  output var  logic       irq_oe_n
);
  logic [7:0] interrupt_mask_q, line_format_control_q, modem_line_control_q, scratch_q;
  logic [15:0] divisor_q;
  logic [7:0] transmit_holding_q, receive_holding_q;
  logic thr_full_q, tsr_busy_q, rx_ready_q;
  logic overrun_q, par_err_q, frame_err_q, brk_q;
  logic thr_ack_q, line_ack_q;
  logic [3:0] delta_q;
  logic [3:0] rx_s1_q, rx_s2_q;
  uart_ctl_pkg::modem_in_t mod_q, mod_d;
  logic wr_en, rd_en, dlab, loop;
  assign wr_en = cs && wr;
  assign rd_en = cs && rd;
  assign dlab  = line_format_control_q[`FMT_DLAB]; // RL13
  assign loop  = modem_line_control_q[`MCTL_LOOP]; // RL17

  // decoding shared by read and write paths
  function automatic logic hit(input logic [2:0] a, input logic [2:0] want);
    hit = (a == want);
  endfunction : hit

  // control registers; unused upper bits never stored
  always_ff @(posedge clock) begin
    if (srst) begin
      interrupt_mask_q      <= `RST_MASK;
      line_format_control_q <= `RST_FORMAT;
      modem_line_control_q  <= `RST_MODEM_CTL;
      divisor_q             <= `RST_DIVISOR;
      scratch_q             <= 8'h00;
    end else if (wr_en) begin
      if (hit(addr, `ADDR_DATA) && dlab) divisor_q[7:0] <= wdata; // RL13
      if (hit(addr, `ADDR_MASK) && dlab) divisor_q[15:8] <= wdata;
      if (hit(addr, `ADDR_MASK) && !dlab) interrupt_mask_q <= {4'h0, wdata[3:0]}; // RL3
      if (hit(addr, `ADDR_FORMAT)) line_format_control_q <= wdata;
      if (hit(addr, `ADDR_MODEM_CTL)) modem_line_control_q <= {3'h0, wdata[4:0]}; // RL17
      if (hit(addr, `ADDR_SCRATCH)) scratch_q <= wdata;
    end
  end

  // two-flop synchronisers for serial and modem inputs
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_s1_q <= 4'hF;
      rx_s2_q <= 4'hF;
    end else begin
      rx_s1_q <= {rx_pin, cts_n, dsr_n, ring_indicate_n};
      rx_s2_q <= rx_s1_q;
    end
  end
  logic cd_s1_q, cd_s2_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      cd_s1_q <= 1'b1;
      cd_s2_q <= 1'b1;
    end else begin
      cd_s1_q <= carrier_detect_n;
      cd_s2_q <= cd_s1_q;
    end
  end

  // modem inputs, looped from control bits in diagnostic mode
  always_comb begin
    if (loop) begin
      mod_d.cts     = modem_line_control_q[`MCTL_RTS]; // RL23
      mod_d.dsr     = modem_line_control_q[`MCTL_DTR];
      mod_d.ring    = modem_line_control_q[`MCTL_RING]; // RL16
      mod_d.carrier = modem_line_control_q[`MCTL_OUT2]; // RL15
    end else begin
      mod_d.cts     = ~rx_s2_q[2];
      mod_d.dsr     = ~rx_s2_q[1];
      mod_d.ring    = ~rx_s2_q[0];
      mod_d.carrier = ~cd_s2_q;
    end
  end
  logic msr_rd;
  assign msr_rd = rd_en && hit(addr, `ADDR_MODEM_IN);
  // change flags; a change in the read cycle survives
  always_ff @(posedge clock) begin
    if (srst) begin
      mod_q   <= '0;
      delta_q <= 4'h0;
    end else begin
      mod_q   <= mod_d;
      delta_q <= (msr_rd ? 4'h0 : delta_q) |
                 {mod_d.carrier ^ mod_q.carrier, mod_q.ring & ~mod_d.ring,
                  mod_d.dsr ^ mod_q.dsr, mod_d.cts ^ mod_q.cts};
    end
  end

  // baud tick at sixteen times the bit rate
  logic [15:0] baud_cnt_q;
  logic        tick;
  assign tick = (baud_cnt_q == 16'h0001) || (divisor_q == 16'h0000);
  always_ff @(posedge clock) begin
    if (srst || tick) baud_cnt_q <= divisor_q;
    else baud_cnt_q <= baud_cnt_q - 16'h0001;
  end

  // format helpers
  logic [2:0] nbits_m1;
  logic       par_en, tx_line, rx_line;
  assign nbits_m1 = 3'h4 + {1'b0, line_format_control_q[1:0]}; // RL7
  assign par_en   = line_format_control_q[`FMT_PAR_EN]; // RL9
  function automatic logic par_of(input logic [7:0] d, input logic [2:0] m1, input logic [7:0] f);
    logic [7:0] msk;
    msk = 8'hFF >> (3'h7 - m1);
    if (f[`FMT_FORCE]) par_of = ~f[`FMT_EVEN]; // RL11
    else par_of = ^(d & msk) ^ ~f[`FMT_EVEN]; // RL10
  endfunction : par_of

  // transmitter; holding register loads shifter when idle
  uart_ctl_pkg::tx_state_t tx_st_q;
  logic [7:0] tsr_q;
  logic [2:0] tx_bit_q;
  logic [4:0] tx_tick_q;
  logic       tx_out_q, tx_par_phase_q;
  logic [5:0] stop_len;
  // one and a half stops only for five-bit words
  assign stop_len = !line_format_control_q[`FMT_STOP] ? 6'd16 :
                    (line_format_control_q[1:0] == 2'b00) ? 6'd24 : 6'd32; // RL8
  logic [5:0] tx_stop_q;
  logic thr_wr;
  assign thr_wr = wr_en && hit(addr, `ADDR_DATA) && !dlab;
  always_ff @(posedge clock) begin
    if (srst) begin
      thr_full_q <= 1'b0;
      transmit_holding_q <= 8'h00;
    end else begin
      if (thr_wr) begin
        transmit_holding_q <= wdata; // RL25
        thr_full_q <= 1'b1;
      end else if (tx_st_q == uart_ctl_pkg::TX_IDLE && thr_full_q) begin
        thr_full_q <= 1'b0;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_st_q <= uart_ctl_pkg::TX_IDLE;
      tsr_q <= 8'h00;
      tx_bit_q <= 3'h0;
      tx_tick_q <= 5'h0;
      tx_out_q <= 1'b1;
      tx_par_phase_q <= 1'b0;
      tx_stop_q <= 6'h0;
      tsr_busy_q <= 1'b0;
    end else begin
      case (tx_st_q)
        uart_ctl_pkg::TX_IDLE: begin
          tx_out_q <= 1'b1;
          tsr_busy_q <= thr_full_q;
          if (thr_full_q && !thr_wr) begin
            tsr_q <= transmit_holding_q;
            tx_st_q <= uart_ctl_pkg::TX_START;
            tx_tick_q <= 5'h0;
          end
        end
        uart_ctl_pkg::TX_START: if (tick) begin
          tx_out_q <= 1'b0;
          tx_tick_q <= tx_tick_q + 5'h1;
          if (tx_tick_q == 5'h0F) begin
            tx_tick_q <= 5'h0;
            tx_bit_q <= 3'h0;
            tx_par_phase_q <= 1'b0;
            tx_st_q <= uart_ctl_pkg::TX_BITS;
          end
        end
        uart_ctl_pkg::TX_BITS: if (tick) begin
          tx_out_q <= tx_par_phase_q ? par_of(tsr_q, nbits_m1, line_format_control_q) : tsr_q[tx_bit_q];
          tx_tick_q <= tx_tick_q + 5'h1;
          if (tx_tick_q == 5'h0F) begin
            tx_tick_q <= 5'h0;
            if (tx_par_phase_q || (tx_bit_q == nbits_m1 && !par_en)) begin
              tx_st_q <= uart_ctl_pkg::TX_STOP;
              tx_stop_q <= 6'h0;
            end else if (tx_bit_q == nbits_m1) begin
              tx_par_phase_q <= 1'b1; // RL9
            end else begin
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        end
        uart_ctl_pkg::TX_STOP: if (tick) begin
          tx_out_q <= 1'b1;
          tx_stop_q <= tx_stop_q + 6'h1;
          if (tx_stop_q == stop_len - 6'h1) tx_st_q <= uart_ctl_pkg::TX_IDLE; // RL8
        end
        default: tx_st_q <= uart_ctl_pkg::TX_IDLE;
      endcase
    end
  end
  // loop-back keeps the pin idle high even in break; otherwise break wins over the transmitter
  assign tx_line = tx_out_q && !line_format_control_q[`FMT_BREAK];
  always_ff @(posedge clock) begin
    if (srst) tx_pin <= 1'b1;
    else tx_pin <= loop ? 1'b1 : tx_line; // RL12
  end

  // receiver: mid-bit sampling at 16x, assembled words go through the fifo
  uart_ctl_pkg::rx_state_t rx_st_q;
  uart_ctl_pkg::rx_word_t  rx_word, fifo_word;
  logic [7:0] rsr_q;
  logic [2:0] rx_bit_q;
  logic [3:0] rx_tick_q;
  logic rx_par_phase_q, rx_par_bad_q, rx_zero_q, rx_push_q;
  logic fifo_in_ready, fifo_valid, fifo_ready;
  assign rx_line = loop ? tx_line : rx_s2_q[3];
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_st_q <= uart_ctl_pkg::RX_IDLE;
      rsr_q <= 8'h00;
      rx_bit_q <= 3'h0;
      rx_tick_q <= 4'h0;
      rx_par_phase_q <= 1'b0;
      rx_par_bad_q <= 1'b0;
      rx_zero_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word <= '0;
    end else begin
      if (fifo_in_ready) rx_push_q <= 1'b0;
      case (rx_st_q)
        uart_ctl_pkg::RX_IDLE: if (!rx_line) begin
          rx_st_q <= uart_ctl_pkg::RX_START;
          rx_tick_q <= 4'h0;
        end
        uart_ctl_pkg::RX_START: if (tick) begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == `START_MID) begin
            rx_tick_q <= 4'h0;
            rx_bit_q <= 3'h0;
            rx_par_phase_q <= 1'b0;
            rx_zero_q <= 1'b1;
            rsr_q <= 8'h00;
            // false start rejected at mid-bit
            rx_st_q <= rx_line ? uart_ctl_pkg::RX_IDLE : uart_ctl_pkg::RX_BITS;
          end
        end
        uart_ctl_pkg::RX_BITS: if (tick) begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == 4'hF) begin
            rx_zero_q <= rx_zero_q & ~rx_line;
            if (rx_par_phase_q) begin
              rx_par_bad_q <= rx_line != par_of(rsr_q, nbits_m1, line_format_control_q); // RL20
              rx_st_q <= uart_ctl_pkg::RX_STOP;
            end else begin
              rsr_q[rx_bit_q] <= rx_line;
              rx_par_bad_q <= 1'b0;
              if (rx_bit_q == nbits_m1) begin
                if (par_en) rx_par_phase_q <= 1'b1; // RL9
                else rx_st_q <= uart_ctl_pkg::RX_STOP;
              end else begin
                rx_bit_q <= rx_bit_q + 3'h1;
              end
            end
          end
        end
        uart_ctl_pkg::RX_STOP: if (tick) begin
          rx_tick_q <= rx_tick_q + 4'h1;
          if (rx_tick_q == 4'hF) begin
            rx_word.data <= rsr_q;
            rx_word.par_err <= rx_par_bad_q;
            rx_word.frame_err <= !rx_line; // RL20
            rx_word.brk <= rx_zero_q && !rx_line; // RL21
            rx_push_q <= 1'b1;
            // a long break gives one break word per frame time
            rx_st_q <= uart_ctl_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= uart_ctl_pkg::RX_IDLE;
      endcase
    end
  end

  uart_fifo #(.WIDTH(11), .DEPTH(16)) rx_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_data   (rx_word),
    .in_valid  (rx_push_q),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_word),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready)
  );
  logic rhr_rd, lsr_rd, isr_rd;
  assign rhr_rd = rd_en && hit(addr, `ADDR_DATA) && !dlab;
  assign lsr_rd = rd_en && hit(addr, `ADDR_LINE_FLAGS);
  assign isr_rd = rd_en && hit(addr, `ADDR_IDENT);
  // fifo drains only into an empty or just-read holding register
  assign fifo_ready = !rx_ready_q || rhr_rd;
  // a word finishing while the previous one still waits on a full fifo
  logic ovr_evt;
  assign ovr_evt = rx_st_q == uart_ctl_pkg::RX_STOP && tick && rx_tick_q == 4'hF && rx_push_q && !fifo_in_ready;
  // any fresh line error re-arms the line source after an acknowledge
  logic line_new;
  assign line_new = ovr_evt || (fifo_valid && fifo_ready &&
                    (fifo_word.par_err || fifo_word.frame_err || fifo_word.brk));

  // holding register, overrun and error flags; a set beats a read clear
  always_ff @(posedge clock) begin
    if (srst) begin
      receive_holding_q <= 8'h00;
      rx_ready_q <= 1'b0;
      overrun_q <= 1'b0;
      par_err_q <= 1'b0;
      frame_err_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      if (fifo_valid && fifo_ready) begin
        receive_holding_q <= fifo_word.data;
        rx_ready_q <= 1'b1; // RL18
      end else if (rhr_rd) begin
        rx_ready_q <= 1'b0; // RL18
      end
      overrun_q   <= (overrun_q && !lsr_rd) || ovr_evt; // RL19
      par_err_q   <= (par_err_q && !lsr_rd) || (fifo_valid && fifo_ready && fifo_word.par_err); // RL20
      frame_err_q <= (frame_err_q && !lsr_rd) || (fifo_valid && fifo_ready && fifo_word.frame_err); // RL20
      brk_q       <= (brk_q && !lsr_rd) || (fifo_valid && fifo_ready && fifo_word.brk); // RL21
    end
  end

  // interrupt sources and priority
  logic line_src, rx_src, tx_src, modem_src;
  logic [3:0] ident;
  logic [7:0] lsr_val;
  assign lsr_val = {1'b0, !thr_full_q && !tsr_busy_q, !thr_full_q, brk_q, frame_err_q,
                    par_err_q, overrun_q, rx_ready_q}; // RL22
  assign line_src  = interrupt_mask_q[2] && (|lsr_val[4:1]) && !line_ack_q; // RL3
  assign rx_src    = interrupt_mask_q[0] && rx_ready_q; // RL1
  assign tx_src    = interrupt_mask_q[1] && !thr_full_q && !thr_ack_q; // RL2
  assign modem_src = interrupt_mask_q[3] && (|delta_q); // RL3
  always_comb begin
    if (line_src) ident = `IDENT_LINE; // RL5
    else if (rx_src) ident = `IDENT_RX;
    else if (tx_src) ident = `IDENT_TX;
    else if (modem_src) ident = `IDENT_MODEM;
    else ident = `IDENT_NONE; // RL6
  end
  // identification read acknowledges only the source it reported
  always_ff @(posedge clock) begin
    if (srst) begin
      thr_ack_q <= 1'b0;
      line_ack_q <= 1'b0;
    end else begin
      if (thr_wr || thr_full_q) thr_ack_q <= 1'b0;
      else if (isr_rd && ident == `IDENT_TX) thr_ack_q <= 1'b1; // RL4
      if (lsr_rd || line_new) line_ack_q <= 1'b0;
      else if (isr_rd && ident == `IDENT_LINE) line_ack_q <= 1'b1; // RL4
    end
  end
  logic any_src;
  assign any_src = line_src || rx_src || tx_src || modem_src;

  // registered outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      irq <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      dtr_n <= loop || !modem_line_control_q[`MCTL_DTR]; // RL14
      rts_n <= loop || !modem_line_control_q[`MCTL_RTS]; // RL14
      irq <= any_src; // RL24
      irq_oe_n <= loop || !modem_line_control_q[`MCTL_OUT2]; // RL15
    end
  end
  always_ff @(posedge clock) begin
    if (srst) rdata <= 8'h00;
    else if (rd_en) begin
      case (addr)
        `ADDR_DATA:       rdata <= dlab ? divisor_q[7:0] : receive_holding_q;
        `ADDR_MASK:       rdata <= dlab ? divisor_q[15:8] : interrupt_mask_q;
        `ADDR_IDENT:      rdata <= {4'h0, ident}; // RL6
        `ADDR_FORMAT:     rdata <= line_format_control_q;
        `ADDR_MODEM_CTL:  rdata <= modem_line_control_q;
        `ADDR_LINE_FLAGS: rdata <= lsr_val;
        `ADDR_MODEM_IN:   rdata <= {mod_q.carrier, mod_q.ring, mod_q.dsr, mod_q.cts, delta_q};
        default:          rdata <= scratch_q;
      endcase
    end
  end

  // checks
  AST_IDENT_PRIO: assert property (@(posedge clock) disable iff (srst) // RL5
    rd_en && addr == `ADDR_IDENT && line_src |=> rdata[3:0] == `IDENT_LINE) else $error("line source not on top");
  AST_IRQ_FOLLOW: assert property (@(posedge clock) disable iff (srst) // RL24
    any_src |=> irq) else $error("irq missed pending source");
  AST_RX_IRQ: assert property (@(posedge clock) disable iff (srst) // RL1
    interrupt_mask_q[0] && rx_ready_q |=> irq) else $error("receive ready irq absent");
  AST_MASK_HI: assert property (@(posedge clock) disable iff (srst) // RL3
    interrupt_mask_q[7:4] == 4'h0) else $error("mask upper bits set");
  AST_BREAK_TX: assert property (@(posedge clock) disable iff (srst) // RL12
    line_format_control_q[`FMT_BREAK] && !loop |=> !tx_pin) else $error("break not low");
  // the pin is registered, so it follows the control bit of the cycle before
  AST_DTR: assert property (@(posedge clock) disable iff (srst) // RL14
    !loop |=> dtr_n == !$past(modem_line_control_q[`MCTL_DTR])) else $error("dtr wrong");
  AST_EMPTY_BOTH: assert property (@(posedge clock) disable iff (srst) // RL22
    thr_full_q |-> !lsr_val[6] && !lsr_val[5]) else $error("empty flags wrong");
  AST_MCTL_HI: assert property (@(posedge clock) disable iff (srst) // RL17
    modem_line_control_q[7:5] == 3'h0) else $error("modem control upper set");
  AST_THR_ACK: assert property (@(posedge clock) disable iff (srst) // RL4
    isr_rd && ident == `IDENT_TX && !thr_wr && !thr_full_q |=> !tx_src) else $error("tx source not cleared");
endmodule : uart_ctl
`default_nettype wire

// *** sim/serial_partner.sv ***
// remote serial device: sends and samples 8-bit frames, lsb first
// assumes divisor 1 in the block, so one bit lasts 16 clocks
`timescale 1ns/100ps
`default_nettype none
module serial_partner (
  input  wire logic       clock,
  input  wire logic       tx_pin,
  output var  logic       rx_pin,
  output var  logic [7:0] got,
  output var  int         got_n
);
  localparam int BIT = 16;
  initial begin
    rx_pin = 1'b1;
    got = 8'h00;
    got_n = 0;
  end
  // one frame; a low stop bit gives a framing fault
  task automatic send(input logic [7:0] b, input logic stp);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock) #2;
      rx_pin = (i == 0) ? 1'b0 : (i == 9) ? stp : b[i-1];
      repeat (BIT - 1) @(posedge clock);
    end
    @(posedge clock) #2;
    rx_pin = 1'b1; // idle level of the line
  endtask : send
  // sample at bit centres; a break also lands here as junk
  initial forever begin
    @(negedge tx_pin);
    repeat (BIT / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clock);
      got[i] = tx_pin;
    end
    got_n++;
  end
endmodule : serial_partner
`default_nettype wire

// *** sim/tb_uart_ctl.sv ***
// self-checking bench for the serial channel control block
// assumes reset divisor 1 and the serial partner on the pins
`timescale 1ns/100ps
`default_nettype none
module tb_uart_ctl;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        cs = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata, got, b;
  logic        rx_pin, tx_pin, dtr_n, rts_n, irq, irq_oe_n;
  logic        p1 = 1'b0;
  logic        p2 = 1'b0;
  logic [31:0] seed = 32'h3F0C696E;
  logic [7:0]  exp_q[$];
  int          got_n, n0;
  int          error_cnt = 0;
  int          comparisons = 0;
  // modem inputs held inactive
  uart_ctl DUT (.clock, .srst, .cs, .addr, .rd, .wr, .wdata, .rdata, .rx_pin, .tx_pin,
    .cts_n(1'b1), .dsr_n(1'b1), .ring_indicate_n(1'b1), .carrier_detect_n(1'b1),
    .dtr_n, .rts_n, .irq, .irq_oe_n);
  serial_partner partner (.clock, .tx_pin, .rx_pin, .got, .got_n);
  always #10 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one host access; a read notes its expected data first
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clock) #2;
    cs = 1'b1;
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(posedge clock) #2;
    cs = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
  endtask : acc
  // bounded wait for an interrupt level, then compare it
  task automatic wt(input int lim, input logic lvl);
    // look off the edge so the registered level has settled
    for (int i = 0; i < lim && irq !== lvl; i++) begin
      @(posedge clock);
      #2;
    end
    chk({7'h00, irq}, {7'h00, lvl});
  endtask : wt
  // read data lands one edge after the strobe
  always @(posedge clock) begin
    p1 <= cs && rd;
    p2 <= p1;
  end
  always @(negedge clock) begin
    if (p2) chk(rdata, exp_q.pop_front());
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    #2;
    srst = 1'b0;
    acc(0, 3'h1, 8'h00);
    acc(0, 3'h2, 8'h01);
    acc(0, 3'h3, 8'h00);
    acc(0, 3'h4, 8'h00);
    acc(0, 3'h5, 8'h60);
    chk({4'h0, dtr_n, rts_n, irq_oe_n, tx_pin}, 8'h0F);
    acc(1, 3'h1, 8'hFF);
    acc(0, 3'h1, 8'h0F);
    acc(1, 3'h1, 8'h00);
    acc(1, 3'h4, 8'h0B);
    acc(0, 3'h4, 8'h0B);
    chk({4'h0, dtr_n, rts_n, irq_oe_n, tx_pin}, 8'h01);
    acc(1, 3'h4, 8'hFF);
    acc(0, 3'h4, 8'h1F);
    acc(0, 3'h6, 8'hFB);
    chk({4'h0, dtr_n, rts_n, irq_oe_n, tx_pin}, 8'h0F);
    acc(1, 3'h4, 8'h00);
    $display("test registers done");
    seed = lfsr(seed);
    b = seed[7:0];
    acc(1, 3'h3, 8'h03);
    acc(1, 3'h1, 8'h02);
    wt(8, 1'b1);
    acc(0, 3'h2, 8'h02);
    acc(0, 3'h2, 8'h01);
    n0 = got_n;
    acc(1, 3'h0, b);
    for (int i = 0; i < 400 && got_n == n0; i++) @(posedge clock);
    chk(got, b);
    repeat (24) @(posedge clock);
    acc(0, 3'h5, 8'h60);
    acc(1, 3'h1, 8'h00);
    wt(8, 1'b0);
    acc(1, 3'h3, 8'h43);
    repeat (2) @(posedge clock);
    chk({7'h00, tx_pin}, 8'h00);
    acc(1, 3'h3, 8'h03);
    repeat (2) @(posedge clock);
    chk({7'h00, tx_pin}, 8'h01);
    $display("test transmit done");
    seed = lfsr(seed);
    b = seed[7:0];
    acc(1, 3'h1, 8'h01);
    partner.send(b, 1'b1);
    wt(40, 1'b1);
    acc(0, 3'h2, 8'h04);
    acc(0, 3'h5, 8'h61);
    acc(0, 3'h0, b);
    wt(8, 1'b0);
    acc(0, 3'h5, 8'h60);
    b = b | 8'h01;
    acc(1, 3'h1, 8'h05);
    partner.send(b, 1'b0);
    wt(40, 1'b1);
    acc(0, 3'h2, 8'h06);
    acc(0, 3'h5, 8'h69);
    acc(0, 3'h2, 8'h04);
    acc(0, 3'h0, b);
    acc(0, 3'h2, 8'h01);
    // even parity, partner sends the wrong parity in its tenth slot
    acc(1, 3'h3, 8'h1B);
    partner.send(b, ~^b);
    wt(40, 1'b1);
    acc(0, 3'h5, 8'h65);
    acc(0, 3'h0, b);
    $display("test receive done");
    repeat (4) @(posedge clock);
    results();
  end
  // the run needs under a thousand cycles; stop a hang well after
  initial begin
    #400000;
    error_cnt++;
    results();
  end
endmodule : tb_uart_ctl
`default_nettype wire
